// file: cic_core.sv
// core interrupt entry, return and instruction sequencing control
// Function
// - with G clear, requests stay pending and execution continues untouched.
// - every reset clears G; an executed status store loads it from accumulator bit 4, an interrupt return sets it.
// - interrupt entry finishes instruction, stacks PC, jumps to vector, five cycles.
// - G clears only after PC is stacked and vector fetched.
// - interrupt return pops address reversed, sets G, resumes there.
// - four sources; three gated by G, software trap always taken.
// - software trap stacks PC and clears G like a maskable entry.
// - priority: wake-up, timer 0, timer 1, software trap lowest.
// - indexed address is 8-bit offset plus ten low pointer bits.
// - direct mode carries an 8-bit data-space address.
// - immediate mode carries an 8-bit constant operand.
// - absolute mode gives 10-bit program address in two bytes; jumps, calls.
// - short branch is PC relative, displacement -31 to +32.
// - add and subtract immediate: two bytes, two cycles, C H Z N.
// - interrupt return is one byte, five cycles, flags untouched.
// - indexed load and store: two bytes, three cycles, no flags.
// - each push lowers the stack pointer by two, each pop raises it.
// - vectors are byte pairs from 0xFF6 upward to 0xFFD.
`timescale 1ns/10ps
`default_nettype none
`include "cic_params.svh"
module cic_core (
   input wire logic clk,
   input wire logic srst,
   input wire logic wakeup_irq,
   input wire logic timer0_irq,
   input wire logic timer1_irq,
   input wire logic instr_valid,
   input wire logic [7:0] instr_opcode,
   input wire logic [7:0] instr_op1,
   input wire logic [7:0] instr_op2,
   output logic instr_ready,
   input wire logic [10:0] x_ptr,
   input wire logic [7:0] acc_value,
   input wire logic [3:0] alu_flags,
   input wire logic [7:0] mem_rdata,
   output logic mem_req,
   output logic mem_we,
   output logic [11:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic [9:0] pc,
   output logic [3:0] sp,
   output logic [7:0] status,
   output cic_pkg::cic_mode_type addr_mode,
   output logic [11:0] eff_addr,
   output logic [7:0] operand,
   output logic irq_entry
);
   import cic_pkg::*;

   // ==========================================================
   // state
   cic_state_type state, next_state;
   cic_cls_type cls, next_cls;
   logic [2:0] step, next_step;
   logic [2:0] last, next_last;
   logic [9:0] next_pc;
   logic [3:0] next_sp;
   logic [3:0] flags, next_flags;
   logic [3:0] fmask, next_fmask;
   logic g, next_g;
   logic [9:0] target, next_target;
   logic [11:0] vec, next_vec;
   logic [9:0] hold, next_hold;
   cic_mode_type next_addr_mode;
   logic [11:0] next_eff_addr;
   logic [7:0] next_operand;
   logic next_irq_entry;

   // ==========================================================
   // decoder and pending sources
   cic_dec_if dif ();
   cic_dec u_dec (
      .d (dif.dec)
   );
   assign dif.opcode = instr_opcode;

   logic [`CIC_IRQ_NUM-1:0] irq_req;
   logic [`CIC_IRQ_NUM-1:0] irq_clr;
   logic [`CIC_IRQ_NUM-1:0] irq_pend;
   logic [`CIC_IRQ_NUM-1:0] irq_win;
   logic irq_any;
   logic take_hw;
   // index order is the priority order
   assign irq_req = {timer1_irq, timer0_irq, wakeup_irq};

   cic_irq_arb u_arb (
      .clk (clk),
      .srst (srst),
      .req (irq_req),
      .clr (irq_clr),
      .pending (irq_pend),
      .winner (irq_win),
      .any (irq_any)
   );

   // pending bits are only looked at in the boundary state
   assign take_hw = (state == CIC_SQ_RUN) && irq_any && g;
   assign irq_clr = take_hw ? irq_win : '0;
   assign instr_ready = (state == CIC_SQ_RUN) && !take_hw;

   // ==========================================================
   // address helpers
   logic [9:0] idx_sum;
   logic [9:0] rel_pc;
   logic [11:0] push_lo_addr, push_hi_addr, pop_hi_addr, pop_lo_addr;
   logic [3:0] flag_src;
   logic [3:0] flags_new;
   logic stack_push, vec_read, stack_pop;

   assign idx_sum = x_ptr[9:0] + {2'h0, instr_op1};
   // displacement field 0..63 maps onto -31..+32
   assign rel_pc = pc + {4'h0, instr_opcode[5:0]} - `CIC_SHORT_BIAS;
   assign push_lo_addr = `CIC_STACK_BASE | {8'h00, sp};
   assign push_hi_addr = `CIC_STACK_BASE | {8'h00, 4'(sp - 4'h1)};
   assign pop_hi_addr = `CIC_STACK_BASE | {8'h00, 4'(sp + 4'h1)};
   assign pop_lo_addr = `CIC_STACK_BASE | {8'h00, 4'(sp + `CIC_SP_STEP)};

   // flag sources: the dedicated carry ops drive C and H themselves
   always_comb begin
      flag_src = alu_flags;
      if (cls == CIC_CLS_SETC) begin
         flag_src = 4'hf;
      end else if (cls == CIC_CLS_CLRC) begin
         flag_src = 4'h0;
      end
   end

   genvar f;
   generate
      for (f = 0; f < 4; f++) begin : g_flag
         assign flags_new[f] = fmask[f] ? flag_src[f] : flags[f];
      end
   endgenerate

   assign stack_push = (cls == CIC_CLS_IRQ) || (cls == CIC_CLS_CALL);
   assign stack_pop = (cls == CIC_CLS_POPC) || (cls == CIC_CLS_POPI);
   assign vec_read = (cls == CIC_CLS_IRQ);

   // ==========================================================
   // stack and vector memory requests (read data same cycle)
   always_comb begin
      mem_req = 1'b0;
      mem_we = 1'b0;
      mem_addr = '0;
      mem_wdata = '0;
      if (state == CIC_SQ_BUSY) begin
         if (stack_push && step == `CIC_STEP_ONE) begin
            mem_req = 1'b1;
            mem_we = 1'b1;
            mem_addr = push_lo_addr;
            mem_wdata = pc[7:0];
         end else if (stack_push && step == `CIC_STEP_TWO) begin
            mem_req = 1'b1;
            mem_we = 1'b1;
            mem_addr = push_hi_addr;
            mem_wdata = {6'h00, pc[9:8]};
         end else if (vec_read && step == `CIC_STEP_THREE) begin
            mem_req = 1'b1;
            mem_addr = vec;
         end else if (vec_read && step == last) begin
            mem_req = 1'b1;
            mem_addr = vec + 12'h001;
         end else if (stack_pop && step == `CIC_STEP_ONE) begin
            mem_req = 1'b1;
            mem_addr = pop_hi_addr;
         end else if (stack_pop && step == `CIC_STEP_TWO) begin
            mem_req = 1'b1;
            mem_addr = pop_lo_addr;
         end
      end
   end

   // ==========================================================
   // sequencer next values
   always_comb begin
      next_state = state;
      next_cls = cls;
      next_step = step;
      next_last = last;
      next_pc = pc;
      next_sp = sp;
      next_flags = flags;
      next_fmask = fmask;
      next_g = g;
      next_target = target;
      next_vec = vec;
      next_hold = hold;
      next_addr_mode = addr_mode;
      next_eff_addr = eff_addr;
      next_operand = operand;
      next_irq_entry = 1'b0;
      case (state)
         CIC_SQ_RUN: begin
            if (take_hw) begin
               // entry begins at the boundary; PC is the return address
               next_state = CIC_SQ_BUSY;
               next_cls = CIC_CLS_IRQ;
               next_step = `CIC_STEP_ONE;
               next_last = 3'(`CIC_CYC_5 - 3'h1);
               next_fmask = `CIC_FM_NONE;
               next_irq_entry = 1'b1;
               if (irq_win[0]) begin
                  next_vec = `CIC_VEC_WAKE;
               end else if (irq_win[1]) begin
                  next_vec = `CIC_VEC_T0;
               end else begin
                  next_vec = `CIC_VEC_T1;
               end
            end else if (instr_valid) begin
               next_cls = dif.cls;
               next_fmask = dif.fmask;
               next_addr_mode = dif.mode;
               next_pc = 10'(pc + {8'h00, dif.bytes});
               next_vec = `CIC_VEC_SOFT;
               next_target = {instr_op1[1:0], instr_op2};
               next_operand = instr_op1;
               next_eff_addr = {4'h0, instr_op1};
               if (dif.mode == CIC_MODE_IDX) begin
                  next_eff_addr = x_ptr[10] ? (`CIC_PROG_BASE | {2'h0, idx_sum})
                                            : {2'h0, idx_sum};
               end
               if (dif.mode == CIC_MODE_REL) begin
                  next_pc = rel_pc;
               end
               if (instr_opcode == `CIC_OP_STORE_DIR && instr_op1 == `CIC_SR_ADDR) begin
                  next_g = acc_value[`CIC_SR_G];
                  next_flags = acc_value[3:0];
               end
               if (instr_opcode == `CIC_OP_STORE_DIR && instr_op1 == `CIC_SP_ADDR) begin
                  next_sp = acc_value[3:0];
               end
               if (dif.cycles == `CIC_CYC_1) begin
                  // single-cycle ops settle flags in the accept cycle
                  for (int b = 0; b < 4; b++) begin
                     if (dif.fmask[b]) begin
                        next_flags[b] = (dif.cls == CIC_CLS_SETC) ? 1'b1 :
                                        (dif.cls == CIC_CLS_CLRC) ? 1'b0 :
                                        alu_flags[b];
                     end
                  end
               end else begin
                  next_state = CIC_SQ_BUSY;
                  next_step = `CIC_STEP_ONE;
                  next_last = 3'(dif.cycles - 3'h1);
               end
            end
         end
         CIC_SQ_BUSY: begin
            next_step = 3'(step + 3'h1);
            if (stack_push && step == `CIC_STEP_TWO) begin
               next_sp = 4'(sp - `CIC_SP_STEP);
            end
            if (stack_pop && step == `CIC_STEP_ONE) begin
               next_hold[9:8] = mem_rdata[1:0];
            end
            if (stack_pop && step == `CIC_STEP_TWO) begin
               next_hold[7:0] = mem_rdata;
               next_sp = 4'(sp + `CIC_SP_STEP);
            end
            if (vec_read && step == `CIC_STEP_THREE) begin
               next_hold[7:0] = mem_rdata;
            end
            if (step == last) begin
               next_state = CIC_SQ_RUN;
               next_flags = flags_new;
               case (cls)
                  CIC_CLS_IRQ: begin
                     next_pc = {mem_rdata[1:0], hold[7:0]};
                     next_g = 1'b0;
                  end
                  CIC_CLS_JUMP, CIC_CLS_CALL: next_pc = target;
                  CIC_CLS_POPC: next_pc = hold;
                  CIC_CLS_POPI: begin
                     next_pc = hold;
                     next_g = 1'b1;
                  end
                  default: next_pc = pc;
               endcase
            end
         end
         default: next_state = CIC_SQ_RUN;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= CIC_SQ_RUN;
         cls <= CIC_CLS_PLAIN;
         step <= '0;
         last <= '0;
         pc <= `CIC_PC_RESET;
         sp <= `CIC_SP_RESET;
         flags <= '0;
         fmask <= '0;
         g <= 1'b0;
         target <= '0;
         vec <= '0;
         hold <= '0;
         addr_mode <= CIC_MODE_INH;
         eff_addr <= '0;
         operand <= '0;
         irq_entry <= 1'b0;
      end else begin
         state <= next_state;
         cls <= next_cls;
         step <= next_step;
         last <= next_last;
         pc <= next_pc;
         sp <= next_sp;
         flags <= next_flags;
         fmask <= next_fmask;
         g <= next_g;
         target <= next_target;
         vec <= next_vec;
         hold <= next_hold;
         addr_mode <= next_addr_mode;
         eff_addr <= next_eff_addr;
         operand <= next_operand;
         irq_entry <= next_irq_entry;
      end
   end

   // R flag lives outside this block and reads as zero here
   assign status = {3'h0, g, flags};
endmodule // cic_core
`default_nettype wire

// file: cic_params.svh
// constants for the core interrupt and instruction control block
`ifndef CIC_PARAMS_SVH
`define CIC_PARAMS_SVH

// ==========================================================
// opcode map (one byte; top two bits set means short branch)
`define CIC_OP_NOP       8'h00
`define CIC_OP_ADC_IMM   8'h01
`define CIC_OP_MINUS_IMM 8'h02
`define CIC_OP_ROTL      8'h03
`define CIC_OP_SETC      8'h04
`define CIC_OP_CLRC      8'h05
`define CIC_OP_LOAD_IDX  8'h06
`define CIC_OP_STORE_IDX 8'h07
`define CIC_OP_LOAD_IMM  8'h08
`define CIC_OP_LOAD_DIR  8'h09
`define CIC_OP_STORE_DIR 8'h0a
`define CIC_OP_LJUMP     8'h0b
`define CIC_OP_CALL      8'h0c
`define CIC_OP_RETURN    8'h0d
`define CIC_OP_IRQ_RETURN 8'h0e
`define CIC_OP_TRAP      8'h0f
`define CIC_SHORT_PREFIX 2'h3
`define CIC_SHORT_BIAS   10'h01f

// ==========================================================
// sizes and cycle counts
`define CIC_BYTES_1      2'h1
`define CIC_BYTES_2      2'h2
`define CIC_BYTES_3      2'h3
`define CIC_CYC_1        3'h1
`define CIC_CYC_2        3'h2
`define CIC_CYC_3        3'h3
`define CIC_CYC_4        3'h4
`define CIC_CYC_5        3'h5

// ==========================================================
// sequence steps within a multi-cycle instruction
`define CIC_STEP_ONE     3'h1
`define CIC_STEP_TWO     3'h2
`define CIC_STEP_THREE   3'h3

// ==========================================================
// addresses and reset values
`define CIC_VEC_T0       12'hff6
`define CIC_VEC_T1       12'hff8
`define CIC_VEC_WAKE     12'hffa
`define CIC_VEC_SOFT     12'hffc
`define CIC_STACK_BASE   12'h030
`define CIC_PROG_BASE    12'hc00
`define CIC_SR_ADDR      8'hcf
`define CIC_SP_ADDR      8'hce
`define CIC_SP_RESET     4'hf
`define CIC_PC_RESET     10'h000
`define CIC_SP_STEP      4'h2

// ==========================================================
// status layout and flag mask positions
`define CIC_F_C          0
`define CIC_F_H          1
`define CIC_F_Z          2
`define CIC_F_N          3
`define CIC_SR_G         4
`define CIC_FM_NONE      4'h0
`define CIC_FM_CHZN      4'hf
`define CIC_FM_CZN       4'hd
`define CIC_FM_CH        4'h3
`define CIC_IRQ_NUM      3

`endif

// file: cic_pkg.sv
// types shared by the core interrupt and instruction control block
package cic_pkg;
   typedef enum logic [2:0] {
      CIC_MODE_INH = 3'b000,
      CIC_MODE_IMM = 3'b001,
      CIC_MODE_DIR = 3'b010,
      CIC_MODE_IDX = 3'b011,
      CIC_MODE_ABS = 3'b100,
      CIC_MODE_REL = 3'b101
   } cic_mode_type;

   typedef enum logic [2:0] {
      CIC_CLS_PLAIN = 3'b000,
      CIC_CLS_JUMP  = 3'b001,
      CIC_CLS_CALL  = 3'b010,
      CIC_CLS_POPC  = 3'b011,
      CIC_CLS_POPI  = 3'b100,
      CIC_CLS_IRQ   = 3'b101,
      CIC_CLS_SETC  = 3'b110,
      CIC_CLS_CLRC  = 3'b111
   } cic_cls_type;

   typedef enum logic [0:0] {
      CIC_SQ_RUN  = 1'b0,
      CIC_SQ_BUSY = 1'b1
   } cic_state_type;
endpackage

// file: cic_dec_if.sv
// decode request and answer between the core and its decoder
`timescale 1ns/10ps
`default_nettype none
interface cic_dec_if;
   import cic_pkg::*;
   logic [7:0] opcode;
   cic_mode_type mode;
   cic_cls_type cls;
   logic [1:0] bytes;
   logic [2:0] cycles;
   logic [3:0] fmask;
   modport core (output opcode, input mode, cls, bytes, cycles, fmask);
   modport dec (input opcode, output mode, cls, bytes, cycles, fmask);
endinterface
`default_nettype wire

// file: cic_dec.sv
// opcode decoder: addressing mode, class, size, cycles, flag mask
`timescale 1ns/10ps
`default_nettype none
`include "cic_params.svh"
module cic_dec (
   cic_dec_if.dec d
);
   import cic_pkg::*;
   always_comb begin
      d.mode = CIC_MODE_INH;
      d.cls = CIC_CLS_PLAIN;
      d.bytes = `CIC_BYTES_1;
      d.cycles = `CIC_CYC_1;
      d.fmask = `CIC_FM_NONE;
      if (d.opcode[7:6] == `CIC_SHORT_PREFIX) begin
         d.mode = CIC_MODE_REL;
         d.cls = CIC_CLS_JUMP;
      end else begin
         case (d.opcode)
            `CIC_OP_ADC_IMM, `CIC_OP_MINUS_IMM: begin
               d.mode = CIC_MODE_IMM;
               d.bytes = `CIC_BYTES_2;
               d.cycles = `CIC_CYC_2;
               d.fmask = `CIC_FM_CHZN;
            end
            `CIC_OP_ROTL: d.fmask = `CIC_FM_CZN;
            `CIC_OP_SETC: begin
               d.cls = CIC_CLS_SETC;
               d.fmask = `CIC_FM_CH;
            end
            `CIC_OP_CLRC: begin
               d.cls = CIC_CLS_CLRC;
               d.fmask = `CIC_FM_CH;
            end
            `CIC_OP_LOAD_IDX, `CIC_OP_STORE_IDX: begin
               d.mode = CIC_MODE_IDX;
               d.bytes = `CIC_BYTES_2;
               d.cycles = `CIC_CYC_3;
            end
            `CIC_OP_LOAD_IMM: begin
               d.mode = CIC_MODE_IMM;
               d.bytes = `CIC_BYTES_2;
               d.cycles = `CIC_CYC_2;
            end
            `CIC_OP_LOAD_DIR, `CIC_OP_STORE_DIR: begin
               d.mode = CIC_MODE_DIR;
               d.bytes = `CIC_BYTES_2;
               d.cycles = `CIC_CYC_2;
            end
            `CIC_OP_LJUMP: begin
               d.mode = CIC_MODE_ABS;
               d.cls = CIC_CLS_JUMP;
               d.bytes = `CIC_BYTES_3;
               d.cycles = `CIC_CYC_4;
            end
            `CIC_OP_CALL: begin
               d.mode = CIC_MODE_ABS;
               d.cls = CIC_CLS_CALL;
               d.bytes = `CIC_BYTES_3;
               d.cycles = `CIC_CYC_5;
            end
            `CIC_OP_RETURN: begin
               d.cls = CIC_CLS_POPC;
               d.cycles = `CIC_CYC_5;
            end
            `CIC_OP_IRQ_RETURN: begin
               d.cls = CIC_CLS_POPI;
               d.cycles = `CIC_CYC_5;
            end
            `CIC_OP_TRAP: begin
               d.cls = CIC_CLS_IRQ;
               d.cycles = `CIC_CYC_5;
            end
            default: d.cls = CIC_CLS_PLAIN;
         endcase
      end
   end
endmodule // cic_dec
`default_nettype wire

// file: cic_irq_arb.sv
// sticky pending latches and fixed-priority pick for hardware sources
`timescale 1ns/10ps
`default_nettype none
`include "cic_params.svh"
module cic_irq_arb (
   input wire logic clk,
   input wire logic srst,
   input wire logic [`CIC_IRQ_NUM-1:0] req,
   input wire logic [`CIC_IRQ_NUM-1:0] clr,
   output logic [`CIC_IRQ_NUM-1:0] pending,
   output logic [`CIC_IRQ_NUM-1:0] winner,
   output logic any
);
   logic [`CIC_IRQ_NUM-1:0] next_pending;
   logic [`CIC_IRQ_NUM:0] above;

   // ==========================================================
   // pending latches; index 0 has the highest priority
   assign above[0] = 1'b0;
   genvar i;
   generate
      for (i = 0; i < `CIC_IRQ_NUM; i++) begin : g_src
         // a request in the clearing cycle is kept
         assign next_pending[i] = req[i] | (pending[i] & ~clr[i]);
         assign winner[i] = pending[i] & ~above[i];
         assign above[i+1] = above[i] | pending[i];
      end
   endgenerate
   assign any = above[`CIC_IRQ_NUM];

   always_ff @(posedge clk) begin
      if (srst) begin
         pending <= '0;
      end else begin
         pending <= next_pending;
      end
   end
endmodule // cic_irq_arb
`default_nettype wire

// file: cic_core_props.sv
// concurrent checks on the ports of the interrupt and instruction control core
`timescale 1ns/10ps
`default_nettype none
module cic_core_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic instr_valid,
   input wire logic [7:0] instr_opcode,
   input wire logic instr_ready,
   input wire logic [3:0] alu_flags,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [11:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic [9:0] pc,
   input wire logic [3:0] sp,
   input wire logic [7:0] status,
   input wire logic irq_entry
);
   logic take;
   assign take = instr_valid && instr_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ==========================================================
   // interrupt entry and return, and instruction flag effects
   property p_reset;
      $fell(srst) |-> pc == 10'h000 && sp == 4'hf && status == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("bad state after reset");
   property p_len;
      irq_entry |-> !instr_ready [*4] ##1 instr_ready;
   endproperty
   a_len: assert property (p_len) else $error("entry length wrong");
   property p_g_late;
      irq_entry |-> status[4] [*4] ##1 !status[4];
   endproperty
   a_g_late: assert property (p_g_late) else $error("mask cleared at wrong time");
   property p_push;
      irq_entry |-> mem_req && mem_we && mem_addr == {8'h03, sp} && mem_wdata == pc[7:0]
         ##1 mem_req && mem_we && mem_addr == {8'h03, sp - 4'h1} && mem_wdata == {6'h00, pc[9:8]};
   endproperty
   a_push: assert property (p_push) else $error("return address push wrong");
   property p_vec;
      irq_entry |-> ##2 mem_req && !mem_we && mem_addr inside {12'hff6, 12'hff8, 12'hffa}
         ##1 mem_req && mem_addr == $past(mem_addr) + 12'h001 ##0 sp == $past(sp, 3) - 4'h2;
   endproperty
   a_vec: assert property (p_vec) else $error("vector fetch wrong");
   property p_unwind;
      take && instr_opcode == 8'h0e |-> ##5 status[4] && sp == $past(sp, 5) + 4'h2
         && status[3:0] == $past(status[3:0], 5);
   endproperty
   a_unwind: assert property (p_unwind) else $error("interrupt return wrong");
   property p_trap;
      take && instr_opcode == 8'h0f |-> ##5 !status[4] && sp == $past(sp, 5) - 4'h2;
   endproperty
   a_trap: assert property (p_trap) else $error("trap entry wrong");
   property p_idx;
      take && instr_opcode inside {8'h06, 8'h07} |-> ##3 $stable(status[3:0]) ##0
         status[3:0] == $past(status[3:0], 3);
   endproperty
   a_idx: assert property (p_idx) else $error("indexed access changed flags");
   property p_carry;
      take && instr_opcode inside {8'h04, 8'h05} |=> status[1:0] == {2{!$past(instr_opcode[0])}};
   endproperty
   a_carry: assert property (p_carry) else $error("carry op flags wrong");
   property p_arith;
      take && instr_opcode inside {8'h01, 8'h02} |-> ##2 status[3:0] == $past(alu_flags);
   endproperty
   a_arith: assert property (p_arith) else $error("arith flags wrong");
   c_entry: cover property (irq_entry);
   c_unwind: cover property (take && instr_opcode == 8'h0e);
   c_trap: cover property (take && instr_opcode == 8'h0f);
endmodule // cic_core_props
bind cic_core cic_core_props i_cic_core_props (.clk, .srst, .instr_valid, .instr_opcode,
   .instr_ready, .alu_flags, .mem_req, .mem_we, .mem_addr, .mem_wdata, .pc, .sp, .status,
   .irq_entry);
`default_nettype wire

// file: cic_mem_model.sv
// stack ram and vector table answering the core's memory port
`timescale 1ns/10ps
`default_nettype none
module cic_mem_model (
   input wire logic clk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [11:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] ram [16];
   logic [7:0] last = 8'h00;
   // idle bus flips every cycle so a stale read never looks valid
   always_ff @(posedge clk) begin
      if (mem_req && mem_we && mem_addr[11:4] == 8'h03)
         ram[mem_addr[3:0]] <= mem_wdata;
      last <= mem_rdata;
   end
   always_comb begin
      if (!mem_req || mem_we)
         mem_rdata = ~last;
      else if (mem_addr[11:4] == 8'hff)
         mem_rdata = mem_addr[0] ? 8'h01 : mem_addr[7:0];
      else
         mem_rdata = ram[mem_addr[3:0]];
   end
endmodule // cic_mem_model
`default_nettype wire

// file: cic_core_tb_top.sv
// self-checking bench for the interrupt and instruction control core
`timescale 1ns/10ps
`default_nettype none
module cic_core_tb_top;
   import cic_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wakeup_irq = 1'b0;
   logic timer0_irq = 1'b0;
   logic timer1_irq = 1'b0;
   logic instr_valid = 1'b0;
   logic [7:0] instr_opcode = 8'h00;
   logic [7:0] instr_op1 = 8'h00;
   logic [7:0] instr_op2 = 8'h00;
   logic [10:0] x_ptr = 11'h405;
   logic [7:0] acc_value = 8'h1a;
   logic [3:0] alu_flags = 4'h0;
   logic instr_ready, mem_req, mem_we, irq_entry;
   logic [11:0] mem_addr, eff_addr;
   logic [7:0] mem_wdata, mem_rdata, status, operand;
   logic [9:0] pc, rp;
   logic [3:0] sp, fl;
   cic_mode_type addr_mode;
   logic [35:0] tbl [9];
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   cic_core i_cic_core (.clk, .srst, .wakeup_irq, .timer0_irq, .timer1_irq, .instr_valid,
      .instr_opcode, .instr_op1, .instr_op2, .instr_ready, .x_ptr, .acc_value, .alu_flags,
      .mem_rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .pc, .sp, .status, .addr_mode,
      .eff_addr, .operand, .irq_entry);
   cic_mem_model i_cic_mem_model (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
   // ==========================================================
   // tasks
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
         miscompares++;
      end
   endtask
   // zero cycles means the count is not checked (an entry follows)
   task automatic issue(input logic [7:0] op, a, b, input logic [3:0] cyc);
      int n;
      @(negedge clk);
      {instr_opcode, instr_op1, instr_op2, instr_valid} = {op, a, b, 1'b1};
      while (instr_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      instr_valid = 1'b0;
      n = 1;
      while (instr_ready !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      if (cyc != 4'h0) chk(12'(n), {8'h00, cyc});
   endtask
   task automatic pulse(input logic [2:0] m);
      @(negedge clk);
      {wakeup_irq, timer0_irq, timer1_irq} = m;
      @(negedge clk);
      {wakeup_irq, timer0_irq, timer1_irq} = 3'h0;
   endtask
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         finish_test();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      // {op, op1, pc delta, cycles, alu flags, expected flags}
      tbl = '{36'h0_1000_22ff, 36'h0_3000_1102, 36'h0_4000_1103, 36'h0_7100_23c3,
         36'h0_2000_2255, 36'h0_5000_11f4, 36'hc_000e_11f4, 36'hf_f002_01f4, 36'h0_6100_2304};
      repeat (5) @(negedge clk);
      srst = 1'b0;
      chk(pc, 12'h000);
      chk(sp, 12'h00f);
      chk(status, 12'h000);
      issue(8'h0f, 8'h00, 8'h00, 4'h5);
      chk(pc, 12'h1fc);
      chk(sp, 12'h00d);
      chk({i_cic_mem_model.ram[14][3:0], i_cic_mem_model.ram[15]}, 12'h001);
      issue(8'h0d, 8'h00, 8'h00, 4'h5);
      chk(pc, 12'h001);
      issue(8'h0b, 8'h02, 8'h34, 4'h4);
      chk(pc, 12'h234);
      issue(8'h0c, 8'h01, 8'h23, 4'h5);
      chk(pc, 12'h123);
      chk({i_cic_mem_model.ram[14][3:0], i_cic_mem_model.ram[15]}, 12'h237);
      issue(8'h0d, 8'h00, 8'h00, 4'h5);
      chk(pc, 12'h237);
      for (int i = 0; i < 9; i++) begin
         alu_flags = tbl[i][7:4];
         rp = pc + {{2{tbl[i][19]}}, tbl[i][19:12]};
         issue(tbl[i][35:28], tbl[i][27:20], 8'h00, tbl[i][11:8]);
         chk(pc, rp);
         chk(status[3:0], tbl[i][3:0]);
      end
      chk(eff_addr, 12'hc15);
      chk(addr_mode, CIC_MODE_IDX);
      // pointer bit 10 low selects data space
      x_ptr = 11'h005;
      issue(8'h06, 8'h10, 8'h00, 4'h3);
      chk(eff_addr, 12'h015);
      issue(8'h09, 8'h55, 8'h00, 4'h2);
      chk(eff_addr, 12'h055);
      chk(addr_mode, CIC_MODE_DIR);
      issue(8'h08, 8'h3c, 8'h00, 4'h2);
      chk(operand, 12'h03c);
      chk(addr_mode, CIC_MODE_IMM);
      // all three sources at once while masked
      pulse(3'h7);
      rp = pc + 10'h001;
      issue(8'h00, 8'h00, 8'h00, 4'h1);
      chk(pc, rp);
      rp = rp + 10'h002;
      issue(8'h0a, 8'hcf, 8'h00, 4'h0);
      chk(pc, 12'h1fa);
      chk(status[4], 12'h000);
      chk(sp, 12'h00d);
      chk({i_cic_mem_model.ram[14][3:0], i_cic_mem_model.ram[15]}, {2'h0, rp});
      issue(8'h0e, 8'h00, 8'h00, 4'h0);
      chk(pc, 12'h1f6);
      issue(8'h0e, 8'h00, 8'h00, 4'h0);
      chk(pc, 12'h1f8);
      fl = status[3:0];
      issue(8'h0e, 8'h00, 8'h00, 4'h5);
      chk(pc, rp);
      chk(status[4], 12'h001);
      chk(sp, 12'h00f);
      chk(status[3:0], fl);
      finish_test();
   end
endmodule // cic_core_tb_top
`default_nettype wire
